// ---- rtl/plc_link_pkg.sv ----
/*
 * constants, register map and helpers for the serial controller link
 * configuration block.
 * assumes 16-bit setup and flag words reached over a word access port.
 */
package plc_link_pkg;

    // ****************************************************************
    // word map of the access port
    // ****************************************************************
    localparam logic [8:0] OFF_PORT_MODE    = 9'h0A0;
    localparam logic [8:0] OFF_PORT_BAUD    = 9'h0A1;
    localparam logic [8:0] OFF_MASTER_SETUP = 9'h0A6;
    localparam logic [8:0] OFF_SLAVE_SETUP  = 9'h0A7;
    localparam logic [8:0] OFF_COMM_ERROR   = 9'h0C0;
    localparam logic [8:0] OFF_UNIT_COMM    = 9'h0C1;
    localparam logic [8:0] OFF_RESTART      = 9'h0C2;
    localparam logic [8:0] OFF_ERROR_CODE   = 9'h0C3;
    localparam logic [8:0] OFF_SET_CHANGED  = 9'h0C4;
    localparam logic [8:0] AREA_BASE        = 9'h100;
    localparam logic [6:0] AREA_WORDS       = 7'h64;

    // ****************************************************************
    // field positions and codes
    // ****************************************************************
    localparam int         MODE_LSB      = 8;
    localparam logic [3:0] MODE_MASTER   = 4'h8;
    localparam logic [3:0] MODE_SLAVE    = 4'h7;
    localparam logic [7:0] BAUD_HIGH     = 8'h0A;
    localparam int         METHOD_BIT    = 15;
    localparam int         WORDS_LSB     = 4;
    localparam logic [3:0] WORDS_DEFAULT = 4'h0;
    localparam logic [3:0] WORDS_MAX     = 4'hA;
    localparam logic [3:0] UNIT_MAX      = 4'h7;
    localparam logic [3:0] NODE_MASTER   = 4'h8;
    localparam int         COMM_ERR_BIT  = 4;
    localparam int         RESTART_BIT   = 0;
    localparam int         SET_CHG_BIT   = 2;
    localparam int         ERR_PARITY    = 2;
    localparam int         ERR_FRAMING   = 3;
    localparam int         ERR_OVERRUN   = 4;
    localparam int         ERR_TIMEOUT   = 5;
    localparam logic [7:0] ERR_CODE_MASK = 8'h3C;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // words per node, zero meaning the full ten
    function automatic logic [3:0] eff_words(input logic [3:0] field);
        return (field == WORDS_DEFAULT || field > WORDS_MAX) ? WORDS_MAX : field;
    endfunction

    // first area word of a node block, master first then units 0..7
    function automatic logic [6:0] block_base(input logic [3:0] node,
                                              input logic [3:0] words);
        logic [6:0] slot;
        slot = (node == NODE_MASTER) ? 7'h00 : 7'({node[2:0]}) + 7'h01;
        return 7'(slot * 7'(words));
    endfunction

endpackage

// ---- rtl/link_area_if.sv ----
/*
 * carrier between the control block and the shared link word area.
 * assumes both ends on the same clock.
 */
`timescale 1ns/1ps
interface link_area_if;
    logic        link_on;    // either link mode active
    logic        master;
    logic        complete;   // complete link method
    logic [3:0]  words;      // effective words per node
    logic [3:0]  own_unit;
    logic        cpu_we;
    logic [6:0]  cpu_idx;
    logic [15:0] cpu_wdata;
    logic [15:0] cpu_rdata;
    logic        rx_valid;
    logic [3:0]  rx_src;
    logic [3:0]  rx_idx;
    logic [15:0] rx_data;
    logic [3:0]  tx_idx;
    logic [15:0] tx_data;

    modport ctrl (output link_on, master, complete, words, own_unit, cpu_we, cpu_idx,
                  cpu_wdata, rx_valid, rx_src, rx_idx, rx_data, tx_idx,
                  input cpu_rdata, tx_data);
    modport area (input link_on, master, complete, words, own_unit, cpu_we, cpu_idx,
                  cpu_wdata, rx_valid, rx_src, rx_idx, rx_data, tx_idx,
                  output cpu_rdata, tx_data);
endinterface

// ---- rtl/link_area.sv ----
/*
 * shared link word area: one hundred words, node blocks laid out in order.
 * assumes configuration inputs already stable for the controller cycle.
 */
`timescale 1ns/1ps
module link_area (
    // clock and reset
    input wire logic    clk,
    input wire logic    rst_n,
    // control side
    link_area_if.area   bus
);
    typedef struct packed {
        logic [99:0][15:0] mem;
    } area_state_t;

    area_state_t cur_q;
    area_state_t nxt_d;
    logic [3:0]  own_node;
    logic [6:0]  own_base;
    logic [6:0]  rx_addr;
    logic [6:0]  tx_addr;
    logic        rx_take;

    // ****************************************************************
    // block placement and acceptance
    // ****************************************************************
    always_comb begin
        own_node = bus.master ? plc_link_pkg::NODE_MASTER : bus.own_unit;
        // own block, fixed slot for slaves under master-only
        own_base = (!bus.master && !bus.complete)
                 ? plc_link_pkg::block_base(4'h0, bus.words)
                 : plc_link_pkg::block_base(own_node, bus.words);
        rx_addr  = plc_link_pkg::block_base(bus.rx_src, bus.words) + 7'(bus.rx_idx);
        tx_addr  = own_base + 7'(bus.tx_idx);
        // complete method copies every other node
        // master-only: master takes slaves, slave takes master
        rx_take  = bus.link_on && bus.rx_valid && bus.rx_idx < bus.words
                 && bus.rx_src <= plc_link_pkg::NODE_MASTER && bus.rx_src != own_node
                 && (bus.complete
                     || (bus.master ? bus.rx_src != plc_link_pkg::NODE_MASTER
                                    : bus.rx_src == plc_link_pkg::NODE_MASTER));
        nxt_d = cur_q;
        if (bus.cpu_we && bus.cpu_idx < plc_link_pkg::AREA_WORDS) begin
            nxt_d.mem[bus.cpu_idx] = bus.cpu_wdata;
        end
        if (rx_take) begin
            nxt_d.mem[rx_addr] = bus.rx_data;   // link wins a shared word
        end
        bus.cpu_rdata = (bus.cpu_idx < plc_link_pkg::AREA_WORDS)
                      ? cur_q.mem[bus.cpu_idx] : 16'h0000;
        bus.tx_data   = (bus.tx_idx < bus.words) ? cur_q.mem[tx_addr] : 16'h0000;
    end

    // area storage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_q <= '0;
        end else begin
            cur_q <= nxt_d;
        end
    end
endmodule // link_area

// ---- rtl/plc_link_ctrl.sv ----
/*
 * serial controller link configuration, status flags and unit polling.
 * assumes a one-cycle CYCLE_END pulse at each controller cycle boundary,
 * and a link engine that reports port errors, restart completion,
 * poll outcomes and received words, all synchronous to SYS_CLK.
 */
// Operation
// - mode code 8 hex makes the port the polling master
// - mode code 7 hex makes the port a polled slave
// - baud codes 00-09 standard speed, 0A hex high speed; default 00
// - link setup bit 15: 0 complete method, 1 master-only; default 0
// - link setup bits 7-4 give words per node, 1 to A hex
// - words field 0 hex means ten words per node
// - link setup bits 3-0 hold highest polled unit, 0 to 7
// - slave setup bits 3-0 hold own unit number, 0 to 7, default 0
// - hundred word area: master block, then units 0-7 in order
// - complete method: every node copies all blocks; absent ones untouched
// - master-only: master takes all slave blocks, slaves only master's
// - comm error flag sets on error, clears on restart, idle in link modes
// - master keeps eight flags, one per communicating unit number
// - software sets restart bit; device restarts and clears it when done
// - error code bits 2-5: parity, framing, overrun, timeout
// - error code cleared on restart, frozen in link modes
// - settings changed flag set during change, cleared on completion
// - all status, error, restart and changed flags zero at power-on
`timescale 1ns/1ps
module plc_link_ctrl (
    // clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        NRST,
    // controller cycle
    input  wire logic        CYCLE_END,
    input  wire logic        SETUP_CHANGE_INSTR,
    // word access port
    input  wire logic [8:0]  WORD_ADDR,
    input  wire logic        WORD_WR,
    input  wire logic [15:0] WORD_WDATA,
    output logic      [15:0] WORD_RDATA,
    // port error events
    input  wire logic        PORT_PARITY_ERR,
    input  wire logic        PORT_FRAMING_ERR,
    input  wire logic        PORT_OVERRUN_ERR,
    input  wire logic        PORT_TIMEOUT_ERR,
    // port restart
    output logic             PORT_RESTART_REQ,
    input  wire logic        PORT_RESTART_DONE,
    // active configuration
    output logic             LINK_MASTER,
    output logic             LINK_SLAVE,
    output logic             LINK_HIGH_SPEED,
    output logic      [7:0]  LINK_BAUD_CODE,
    output logic             LINK_COMPLETE,
    output logic      [3:0]  LINK_WORDS,
    // unit polling
    output logic             POLL_REQ,
    output logic      [2:0]  POLL_UNIT,
    input  wire logic        POLL_OK,
    input  wire logic        POLL_FAIL,
    // link data
    input  wire logic        LINK_RX_VALID,
    input  wire logic [3:0]  LINK_RX_SRC,
    input  wire logic [3:0]  LINK_RX_IDX,
    input  wire logic [15:0] LINK_RX_DATA,
    input  wire logic [3:0]  LINK_TX_IDX,
    output logic      [15:0] LINK_TX_DATA
);
    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [1:0] {
        POLL_IDLE = 2'b00,
        POLL_ISSUE = 2'b01,
        POLL_WAIT = 2'b10
    } poll_state_t;

    typedef struct packed {
        logic [15:0] mode_word;
        logic [15:0] baud_word;
        logic [15:0] master_word;
        logic [15:0] slave_word;
        logic        act_master;
        logic        act_slave;
        logic [7:0]  act_baud;
        logic        act_high;
        logic        act_complete;
        logic [3:0]  act_words;
        logic [2:0]  act_highest;
        logic [3:0]  act_unit;
        logic        comm_err;
        logic [7:0]  unit_comm;
        logic        restart;
        logic [7:0]  err_code;
        logic        set_chg;
        poll_state_t poll_state;
        logic [2:0]  poll_unit;
        logic [15:0] rdata;
        logic [15:0] tx_data;
    } ctrl_state_t;

    ctrl_state_t cur_q;
    ctrl_state_t nxt_d;
    link_area_if area_bus ();

    logic        link_mode;
    logic        wr_setup;
    logic [7:0]  err_events;
    logic        restart_done;
    logic [3:0]  mode_field;
    logic [3:0]  units_field;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // clamp a 4-bit unit field to the legal unit range
    function automatic logic [3:0] clamp_unit(input logic [3:0] field);
        return (field > plc_link_pkg::UNIT_MAX) ? plc_link_pkg::UNIT_MAX : field;
    endfunction

    // word access hit test
    function automatic logic hit(input logic [8:0] addr, input logic [8:0] off);
        return addr == off;
    endfunction

    // ****************************************************************
    // shared area
    // ****************************************************************
    // area control from the active configuration
    always_comb begin
        area_bus.link_on   = cur_q.act_master || cur_q.act_slave;
        area_bus.master    = cur_q.act_master;
        area_bus.complete  = cur_q.act_complete;
        area_bus.words     = cur_q.act_words;
        area_bus.own_unit  = cur_q.act_unit;
        area_bus.cpu_we    = WORD_WR && WORD_ADDR >= plc_link_pkg::AREA_BASE;
        area_bus.cpu_idx   = 7'(WORD_ADDR - plc_link_pkg::AREA_BASE);
        area_bus.cpu_wdata = WORD_WDATA;
        area_bus.rx_valid  = LINK_RX_VALID;
        area_bus.rx_src    = LINK_RX_SRC;
        area_bus.rx_idx    = LINK_RX_IDX;
        area_bus.rx_data   = LINK_RX_DATA;
        area_bus.tx_idx    = LINK_TX_IDX;
    end

    link_area u_area (
        .clk   (SYS_CLK),
        .rst_n (NRST),
        .bus   (area_bus)
    );

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        nxt_d        = cur_q;
        link_mode    = cur_q.act_master || cur_q.act_slave;
        restart_done = cur_q.restart && PORT_RESTART_DONE;
        mode_field   = cur_q.mode_word[plc_link_pkg::MODE_LSB +: 4];
        units_field  = cur_q.master_word[3:0];
        wr_setup     = WORD_WR && (hit(WORD_ADDR, plc_link_pkg::OFF_PORT_MODE)
                     || hit(WORD_ADDR, plc_link_pkg::OFF_PORT_BAUD)
                     || hit(WORD_ADDR, plc_link_pkg::OFF_MASTER_SETUP)
                     || hit(WORD_ADDR, plc_link_pkg::OFF_SLAVE_SETUP));
        err_events   = '0;
        err_events[plc_link_pkg::ERR_PARITY]  = PORT_PARITY_ERR;
        err_events[plc_link_pkg::ERR_FRAMING] = PORT_FRAMING_ERR;
        err_events[plc_link_pkg::ERR_OVERRUN] = PORT_OVERRUN_ERR;
        err_events[plc_link_pkg::ERR_TIMEOUT] = PORT_TIMEOUT_ERR;

        // raw setup words, stored as written
        if (WORD_WR) begin
            case (WORD_ADDR)
                plc_link_pkg::OFF_PORT_MODE:    nxt_d.mode_word   = WORD_WDATA;
                plc_link_pkg::OFF_PORT_BAUD:    nxt_d.baud_word   = WORD_WDATA;
                plc_link_pkg::OFF_MASTER_SETUP: nxt_d.master_word = WORD_WDATA;
                plc_link_pkg::OFF_SLAVE_SETUP:  nxt_d.slave_word  = WORD_WDATA;
                default: ;
            endcase
        end

        // apply setup at the cycle boundary
        if (CYCLE_END) begin
            nxt_d.act_master   = mode_field == plc_link_pkg::MODE_MASTER;
            nxt_d.act_slave    = mode_field == plc_link_pkg::MODE_SLAVE;
            nxt_d.act_baud     = cur_q.baud_word[7:0];
            nxt_d.act_high     = cur_q.baud_word[7:0] == plc_link_pkg::BAUD_HIGH;
            nxt_d.act_complete = !cur_q.master_word[plc_link_pkg::METHOD_BIT];
            nxt_d.act_words    = plc_link_pkg::eff_words(
                                 cur_q.master_word[plc_link_pkg::WORDS_LSB +: 4]);
            nxt_d.act_highest  = 3'(clamp_unit(units_field));
            nxt_d.act_unit     = clamp_unit(cur_q.slave_word[3:0]);
        end

        // comm error flag, idle in link modes
        if (hit(WORD_ADDR, plc_link_pkg::OFF_COMM_ERROR) && WORD_WR) begin
            nxt_d.comm_err = cur_q.comm_err;    // read only word
        end
        if (restart_done) begin
            nxt_d.comm_err = 1'b0;
        end
        if (!link_mode && err_events != 8'h00) begin
            nxt_d.comm_err = 1'b1;              // set wins over restart
        end

        if (WORD_WR && hit(WORD_ADDR, plc_link_pkg::OFF_ERROR_CODE)) begin
            nxt_d.err_code = WORD_WDATA[7:0] & plc_link_pkg::ERR_CODE_MASK;
        end else if (restart_done) begin
            nxt_d.err_code = 8'h00;
        end
        if (!link_mode) begin
            nxt_d.err_code = nxt_d.err_code | err_events;
        end

        if (WORD_WR && hit(WORD_ADDR, plc_link_pkg::OFF_RESTART)) begin
            nxt_d.restart = WORD_WDATA[plc_link_pkg::RESTART_BIT];
        end else if (restart_done) begin
            nxt_d.restart = 1'b0;
        end

        if (CYCLE_END) begin
            nxt_d.set_chg = 1'b0;
        end
        if (WORD_WR && hit(WORD_ADDR, plc_link_pkg::OFF_SET_CHANGED)) begin
            nxt_d.set_chg = WORD_WDATA[plc_link_pkg::SET_CHG_BIT];
        end
        if (wr_setup || SETUP_CHANGE_INSTR) begin
            nxt_d.set_chg = 1'b1;               // new change wins
        end

        // ascending poll sequence at the master
        case (cur_q.poll_state)
            POLL_IDLE: begin
                nxt_d.poll_unit = 3'h0;
                if (cur_q.act_master && !cur_q.restart) begin
                    nxt_d.poll_state = POLL_ISSUE;
                end
            end
            POLL_ISSUE: begin
                nxt_d.poll_state = POLL_WAIT;
            end
            POLL_WAIT: begin
                if (POLL_OK || POLL_FAIL) begin
                    nxt_d.unit_comm[cur_q.poll_unit] = POLL_OK;
                    nxt_d.poll_state = POLL_ISSUE;
                    nxt_d.poll_unit  = (cur_q.poll_unit >= cur_q.act_highest)
                                     ? 3'h0 : cur_q.poll_unit + 3'h1;
                end
            end
            default: begin
                nxt_d.poll_state = POLL_IDLE;
            end
        endcase
        if (!cur_q.act_master || cur_q.restart) begin
            nxt_d.poll_state = POLL_IDLE;
        end
        if (!cur_q.act_master) begin
            nxt_d.unit_comm = 8'h00;
        end

        // registered read data
        nxt_d.rdata = 16'h0000;
        case (WORD_ADDR)
            plc_link_pkg::OFF_PORT_MODE:    nxt_d.rdata = cur_q.mode_word;
            plc_link_pkg::OFF_PORT_BAUD:    nxt_d.rdata = cur_q.baud_word;
            plc_link_pkg::OFF_MASTER_SETUP: nxt_d.rdata = cur_q.master_word;
            plc_link_pkg::OFF_SLAVE_SETUP:  nxt_d.rdata = cur_q.slave_word;
            plc_link_pkg::OFF_COMM_ERROR:
                nxt_d.rdata[plc_link_pkg::COMM_ERR_BIT] = cur_q.comm_err;
            plc_link_pkg::OFF_UNIT_COMM:    nxt_d.rdata[7:0] = cur_q.unit_comm;
            plc_link_pkg::OFF_RESTART:
                nxt_d.rdata[plc_link_pkg::RESTART_BIT] = cur_q.restart;
            plc_link_pkg::OFF_ERROR_CODE:   nxt_d.rdata[7:0] = cur_q.err_code;
            plc_link_pkg::OFF_SET_CHANGED:
                nxt_d.rdata[plc_link_pkg::SET_CHG_BIT] = cur_q.set_chg;
            default: begin
                if (WORD_ADDR >= plc_link_pkg::AREA_BASE) begin
                    nxt_d.rdata = area_bus.cpu_rdata;
                end
            end
        endcase

        // own block word toward the link
        nxt_d.tx_data = link_mode ? area_bus.tx_data : 16'h0000;
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    // everything zero at power-on
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            cur_q <= '0;
        end else begin
            cur_q <= nxt_d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // flops straight to ports, POLL_REQ decoded from the poll state
    assign WORD_RDATA       = cur_q.rdata;
    assign PORT_RESTART_REQ = cur_q.restart;
    assign LINK_MASTER      = cur_q.act_master;
    assign LINK_SLAVE       = cur_q.act_slave;
    assign LINK_HIGH_SPEED  = cur_q.act_high;
    assign LINK_BAUD_CODE   = cur_q.act_baud;
    assign LINK_COMPLETE    = cur_q.act_complete;
    assign LINK_WORDS       = cur_q.act_words;
    assign POLL_REQ         = cur_q.poll_state == POLL_ISSUE;   // one-cycle pulse
    assign POLL_UNIT        = cur_q.poll_unit;
    assign LINK_TX_DATA     = cur_q.tx_data;

endmodule // plc_link_ctrl

// ---- sim/plc_link_ctrl_properties.sv ----
/* port checker for the link configuration block.
   assumes a bind from the bench top file. */
`timescale 1ns/1ps
module plc_link_ctrl_properties (
    // clock and reset
    input wire logic        SYS_CLK,
    input wire logic        NRST,
    // watched ports
    input wire logic        CYCLE_END,
    input wire logic [8:0]  WORD_ADDR,
    input wire logic        WORD_WR,
    input wire logic [15:0] WORD_WDATA,
    input wire logic        PORT_RESTART_REQ,
    input wire logic        PORT_RESTART_DONE,
    input wire logic        LINK_MASTER,
    input wire logic        LINK_HIGH_SPEED,
    input wire logic [7:0]  LINK_BAUD_CODE,
    input wire logic [3:0]  LINK_WORDS,
    input wire logic        POLL_REQ,
    input wire logic [2:0]  POLL_UNIT,
    input wire logic        POLL_OK,
    input wire logic        POLL_FAIL
);
    // ****
    // properties
    // ****
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);
    chk_restart_set: assert property (WORD_WR && WORD_WDATA[0]
        && WORD_ADDR == plc_link_pkg::OFF_RESTART |=> PORT_RESTART_REQ)
        else $error("restart request not raised");
    chk_restart_clear: assert property (PORT_RESTART_REQ
        && PORT_RESTART_DONE && !WORD_WR |=> !PORT_RESTART_REQ)
        else $error("restart request not dropped");
    chk_setup_hold: assert property (!CYCLE_END |=>
        $stable(LINK_MASTER) && $stable(LINK_WORDS))
        else $error("setup changed off a cycle boundary");
    chk_master_cause: assert property ($rose(LINK_MASTER) |-> $past(CYCLE_END))
        else $error("master mode without boundary");
    chk_speed_code: assert property (LINK_HIGH_SPEED == (LINK_BAUD_CODE == 8'h0A))
        else $error("speed flag disagrees with code");
    chk_words_range: assert property (LINK_MASTER |-> LINK_WORDS inside {[4'h1:4'hA]})
        else $error("words per node out of range");
    chk_poll_pulse: assert property (POLL_REQ |=> !POLL_REQ)
        else $error("poll request longer than one cycle");
    chk_poll_unit_held: assert property (POLL_REQ ##1 !(POLL_OK || POLL_FAIL)
        |-> $stable(POLL_UNIT))
        else $error("poll unit moved before answer");
endmodule // plc_link_ctrl_properties

// ---- sim/link_peer_model.sv ----
/* partner: polled units answering the master's polls.
   assumes one-cycle poll request pulses from the block. */
`timescale 1ns/1ps
module link_peer_model #(
    parameter logic [2:0] FAIL_UNIT = 3'h1
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // poll handshake
    input  wire logic       poll_req,
    input  wire logic [2:0] poll_unit,
    output logic            poll_ok,
    output logic            poll_fail
);
    // ****
    // answers
    // ****
    // slower answer for higher units
    always @(posedge clk) begin
        poll_ok <= 1'b0;
        poll_fail <= 1'b0;
        if (nrst && poll_req) begin
            repeat (poll_unit) @(posedge clk);
            poll_ok <= (poll_unit != FAIL_UNIT);
            poll_fail <= (poll_unit == FAIL_UNIT);
        end
    end
endmodule // link_peer_model

// ---- sim/serial_plc_link_config_tb.sv ----
/* bench for the link configuration block.
   assumes the partner model and checker files compiled first. */
`timescale 1ns/1ps
module serial_plc_link_config_tb;
    logic SYS_CLK, NRST, CYCLE_END, SETUP_CHANGE_INSTR, WORD_WR, PORT_RESTART_DONE;
    logic PORT_RESTART_REQ, LINK_MASTER, LINK_SLAVE, LINK_HIGH_SPEED, LINK_COMPLETE;
    logic POLL_REQ, POLL_OK, POLL_FAIL, LINK_RX_VALID;
    logic [2:0]  POLL_UNIT;
    logic [3:0]  errs, LINK_WORDS, LINK_RX_SRC, LINK_RX_IDX, LINK_TX_IDX;
    logic [7:0]  LINK_BAUD_CODE;
    logic [8:0]  WORD_ADDR;
    logic [15:0] WORD_WDATA, WORD_RDATA, LINK_RX_DATA, LINK_TX_DATA;
    int          err_total, comparisons;
    wire PORT_PARITY_ERR = errs[0];
    wire PORT_FRAMING_ERR = errs[1];
    wire PORT_OVERRUN_ERR = errs[2];
    wire PORT_TIMEOUT_ERR = errs[3];
    plc_link_ctrl u_dut (.*);
    link_peer_model #(.FAIL_UNIT(3'h1)) u_peer (.clk(SYS_CLK), .nrst(NRST),
        .poll_req(POLL_REQ), .poll_unit(POLL_UNIT), .poll_ok(POLL_OK), .poll_fail(POLL_FAIL));
    always #20 SYS_CLK = ~SYS_CLK;
    // ****
    // helpers
    // ****
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge SYS_CLK);
        #1;
    endtask
    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        {WORD_ADDR, WORD_WDATA, WORD_WR} = {a, d, 1'b1};
        tick(1);
        WORD_WR = 1'b0;
        tick(1);
    endtask
    task automatic rd(input logic [8:0] a, input logic [15:0] e);
        WORD_ADDR = a;
        tick(2);
        chk(WORD_RDATA, e);
    endtask
    task automatic cyc();
        CYCLE_END = 1'b1;
        tick(1);
        CYCLE_END = 1'b0;
    endtask
    task automatic finish_test();
        $display("err_total %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic next_poll(input logic [2:0] u);
        int n;
        n = 0;
        while (POLL_REQ !== 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        if (n == 40) err_total++;
        if (n == 40) finish_test();
        chk(16'(POLL_UNIT), 16'(u));
        tick(1);
    endtask
    // ****
    // scenarios
    // ****
    task automatic t_reset();
        for (logic [8:0] a = 9'h0C0; a <= 9'h0C4; a++) rd(a, 16'h0000);
        wr(plc_link_pkg::OFF_COMM_ERROR, 16'hFFFF);
        rd(plc_link_pkg::OFF_COMM_ERROR, 16'h0000);
        rd(9'h1FF, 16'h0000);
    endtask
    task automatic t_mode();
        wr(plc_link_pkg::OFF_PORT_MODE, 16'h0700);
        rd(plc_link_pkg::OFF_SET_CHANGED, 16'h0004);
        chk({LINK_MASTER, LINK_SLAVE}, 16'h0000);
        cyc();
        chk({LINK_MASTER, LINK_SLAVE}, 16'h0001);
        rd(plc_link_pkg::OFF_SET_CHANGED, 16'h0000);
        rd(plc_link_pkg::OFF_PORT_MODE, 16'h0700);
        SETUP_CHANGE_INSTR = 1'b1;
        tick(1);
        SETUP_CHANGE_INSTR = 1'b0;
        rd(plc_link_pkg::OFF_SET_CHANGED, 16'h0004);
        wr(plc_link_pkg::OFF_PORT_MODE, 16'h0000);
        for (int i = 0; i < 3; i++) begin
            wr(plc_link_pkg::OFF_PORT_BAUD, 16'(i * 5));
            cyc();
            chk({LINK_HIGH_SPEED, LINK_BAUD_CODE}, 16'(i * 5) | 16'(i / 2 * 256));
        end
    endtask
    task automatic t_errors();
        for (int i = 0; i < 4; i++) begin
            errs = 4'(1 << i);
            tick(1);
            errs = 4'h0;
            rd(plc_link_pkg::OFF_ERROR_CODE, 16'((4 << (i + 1)) - 4));
        end
        rd(plc_link_pkg::OFF_COMM_ERROR, 16'h0010);
        wr(plc_link_pkg::OFF_RESTART, 16'h0001);
        chk(16'(PORT_RESTART_REQ), 16'h0001);
        PORT_RESTART_DONE = 1'b1;
        tick(1);
        PORT_RESTART_DONE = 1'b0;
        chk(16'(PORT_RESTART_REQ), 16'h0000);
        rd(plc_link_pkg::OFF_ERROR_CODE, 16'h0000);
        rd(plc_link_pkg::OFF_COMM_ERROR, 16'h0000);
        wr(plc_link_pkg::OFF_ERROR_CODE, 16'hFFD4);
        rd(plc_link_pkg::OFF_ERROR_CODE, 16'h0014);
    endtask
    task automatic t_master();
        wr(plc_link_pkg::OFF_MASTER_SETUP, 16'h0002);
        cyc();
        chk({LINK_COMPLETE, LINK_WORDS}, 16'h001A);
        wr(plc_link_pkg::OFF_MASTER_SETUP, 16'h8022);
        wr(plc_link_pkg::OFF_PORT_MODE, 16'h0800);
        cyc();
        chk({LINK_MASTER, LINK_COMPLETE, LINK_WORDS}, 16'h0022);
        next_poll(3'h0);
        next_poll(3'h1);
        next_poll(3'h2);
        next_poll(3'h0);
        rd(plc_link_pkg::OFF_UNIT_COMM, 16'h0005);
        {LINK_RX_SRC, LINK_RX_IDX, LINK_RX_DATA, LINK_RX_VALID} = {8'h21, 16'hBEEF, 1'b1};
        tick(1);
        LINK_RX_VALID = 1'b0;
        rd(plc_link_pkg::AREA_BASE + 9'h007, 16'hBEEF);
        errs = 4'hF;
        tick(1);
        errs = 4'h0;
        rd(plc_link_pkg::OFF_ERROR_CODE, 16'h0014);
        rd(plc_link_pkg::OFF_COMM_ERROR, 16'h0000);
    endtask
    task automatic t_slave();
        wr(plc_link_pkg::OFF_SLAVE_SETUP, 16'h0003);
        wr(plc_link_pkg::OFF_MASTER_SETUP, 16'h0022);
        wr(plc_link_pkg::OFF_PORT_MODE, 16'h0700);
        wr(plc_link_pkg::AREA_BASE + 9'h009, 16'h5A5A);
        cyc();
        LINK_TX_IDX = 4'h1;
        {LINK_RX_SRC, LINK_RX_IDX, LINK_RX_DATA, LINK_RX_VALID} = {8'h21, 16'h0BAD, 1'b1};
        tick(1);
        LINK_RX_VALID = 1'b0;
        tick(1);
        chk(LINK_TX_DATA, 16'h5A5A);
        rd(plc_link_pkg::AREA_BASE + 9'h007, 16'h0BAD);
    endtask
    initial begin
        {SYS_CLK, NRST, CYCLE_END, SETUP_CHANGE_INSTR, WORD_WR, PORT_RESTART_DONE} = '0;
        {errs, LINK_RX_VALID, LINK_RX_SRC, LINK_RX_IDX, LINK_TX_IDX} = '0;
        {WORD_ADDR, WORD_WDATA, LINK_RX_DATA, err_total, comparisons} = '0;
        tick(8);
        NRST = 1'b1;
        t_reset();
        t_mode();
        t_errors();
        t_master();
        t_slave();
        finish_test();
    end
endmodule // serial_plc_link_config_tb
bind plc_link_ctrl plc_link_ctrl_properties u_props (.*);
